/* hw/pao_adc_path.sv */
/*
 * Digital side of a pipelined sampling converter: track-and-hold phase
 * sequencing, nine 2-bit pipeline stages advanced on both convert clock
 * edges, time alignment, error correction, output coding and the output
 * pin drivers, plus a buffered capture tap.
 * Assumes the convert clock and all inputs are synchronous to clk and that
 * the convert clock stays at each level for at least two clk cycles.
 */
// Behaviour
// - A sample's word appears 6.5 convert cycles after the falling edge that captured it.
// - Each sample yields one 10-bit word on the parallel output pins.
// - In straight offset binary a positive full-scale input gives all ones.
// - With the top-bit-invert select high only the top bit is inverted, giving two's complement.
// - While the output-float control is high the result word pins are released.
// - The quantizer is nine stages, each resolving a 2-bit code; all but the last pass a residue on.
// - Both the rising and the falling convert clock edge advance the pipeline stages.
// - Every stage's code is delayed to line up with later stages before error correction.
// - Track and hold run on two non-overlapping phases, sampling in the first and holding in the second.
// - The top output bit carries the most significant bit and the bottom bit the least.
module pao_adc_path
    import pao_pkg::*;
#(
    parameter int AIN_W     = AIN_W_DEF,
    parameter int TAP_DEPTH = TAP_DEPTH_DEF
) (
    // Clock, reset and enable.
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    // Convert clock and sampled input level.
    input  wire logic              conv_clk,
    input  wire logic [AIN_W-1:0]  ain_level,
    // Static straps.
    input  wire logic              top_bit_invert_sel,
    input  wire logic              out_float,
    // Parallel result pins.
    output logic [WORD_W-1:0]      result_word,
    output logic                   result_oe,
    output logic                   word_strobe,
    // Track-and-hold phases.
    output logic                   track_phase,
    output logic                   hold_phase,
    // Capture tap.
    output logic [WORD_W-1:0]      tap_data,
    output logic                   tap_valid,
    input  wire logic              tap_ready,
    output logic                   tap_space,
    output logic                   tap_lost
);
    localparam int STAGES = STAGES_DEF;
    localparam int CODE_W = STAGE_BITS * STAGES;
    localparam int TAIL   = LATENCY_HALF_CYCLES - STAGES - 2;
    localparam logic [AIN_W-1:0] TH_LO = {3'h3, {(AIN_W-3){1'b0}}};
    localparam logic [AIN_W-1:0] TH_HI = {3'h5, {(AIN_W-3){1'b0}}};

    // Stage decision with redundancy: codes 0..2 keep the residue in range.
    function automatic logic [1:0] stage_decide(input logic [AIN_W-1:0] x);
        if (x < TH_LO) begin
            return 2'h0;
        end else if (x < TH_HI) begin
            return 2'h1;
        end
        return 2'h2;
    endfunction

    // Residue is twice the input less the DAC level d times half of full scale.
    function automatic logic [AIN_W-1:0] stage_residue(input logic [AIN_W-1:0] x,
                                                       input logic [1:0]       d);
        logic [AIN_W:0] t;
        t = {x, 1'b0} - {d, {(AIN_W-1){1'b0}}};
        return t[AIN_W-1:0];
    endfunction

    // Overlapping add of aligned stage codes; the sum stays below 2**WORD_W
    // because the residues are exact, so no saturation is needed.
    function automatic logic [WORD_W-1:0] correct(input logic [CODE_W-1:0] c);
        logic [WORD_W:0] acc;
        acc = '0;
        for (int i = 0; i < STAGES; i++) begin
            acc = acc + ((WORD_W+1)'(c[STAGE_BITS*i +: STAGE_BITS]) << (STAGES - 1 - i));
        end
        return acc[WORD_W-1:0];
    endfunction

    function automatic logic [WORD_W-1:0] apply_coding(input logic [WORD_W-1:0] w,
                                                       input logic             inv);
        logic [WORD_W-1:0] r;
        r = w;
        r[RESULT_BIT_TOP] = w[RESULT_BIT_TOP] ^ inv;
        return r;
    endfunction

    // Convert clock edges and track-and-hold phases.
    logic             conv_q_r, conv_q_nxt;
    logic             rise, fall, sub_edge;
    pao_th_state_type state_r, state_nxt;
    logic             phi1_r, phi1_nxt, phi2_r, phi2_nxt;

    always_comb begin
        conv_q_nxt = conv_clk;
        rise       = !conv_q_r && conv_clk;
        fall       = conv_q_r && !conv_clk;
        sub_edge   = rise || fall;
        case (state_r)
            TH_TRACK: state_nxt = fall ? TH_GAP_A : TH_TRACK;
            TH_GAP_A: state_nxt = TH_HOLD;
            TH_HOLD:  state_nxt = rise ? TH_GAP_B : TH_HOLD;
            TH_GAP_B: state_nxt = TH_TRACK;
            default:  state_nxt = TH_TRACK;
        endcase
        phi1_nxt = (state_nxt == TH_TRACK);
        phi2_nxt = (state_nxt == TH_HOLD);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            conv_q_r <= 1'b0;
            state_r  <= TH_TRACK;
            phi1_r   <= 1'b1;
            phi2_r   <= 1'b0;
        end else if (ce) begin
            conv_q_r <= conv_q_nxt;
            state_r  <= state_nxt;
            phi1_r   <= phi1_nxt;
            phi2_r   <= phi2_nxt;
        end
    end

    // Hold register, quantizer stages, correction and alignment tail.
    // Valid flags carry a bubble in every other half cycle, so each stage
    // sees a new sample once per convert cycle.
    logic [AIN_W-1:0]  hold_r, hold_nxt;
    logic              hold_v_r, hold_v_nxt;
    logic [AIN_W-1:0]  res_r [STAGES-1];
    logic [AIN_W-1:0]  res_nxt [STAGES-1];
    logic [CODE_W-1:0] codes_r [STAGES];
    logic [CODE_W-1:0] codes_nxt [STAGES];
    logic [STAGES-1:0] v_r, v_nxt;
    logic [WORD_W-1:0] corr_r, corr_nxt;
    logic              corr_v_r, corr_v_nxt;
    logic [WORD_W-1:0] tail_r [TAIL];
    logic [WORD_W-1:0] tail_nxt [TAIL];
    logic [TAIL-1:0]   tail_v_r, tail_v_nxt;

    always_comb begin
        hold_nxt   = hold_r;
        hold_v_nxt = hold_v_r;
        res_nxt    = res_r;
        codes_nxt  = codes_r;
        v_nxt      = v_r;
        corr_nxt   = corr_r;
        corr_v_nxt = corr_v_r;
        tail_nxt   = tail_r;
        tail_v_nxt = tail_v_r;
        if (sub_edge) begin
            if (fall) begin
                hold_nxt = ain_level;
            end
            hold_v_nxt = fall;
            codes_nxt[0] = '0;
            codes_nxt[0][STAGE_BITS-1:0] = stage_decide(hold_r);
            res_nxt[0] = stage_residue(hold_r, stage_decide(hold_r));
            v_nxt[0]   = hold_v_r;
            for (int i = 1; i < STAGES - 1; i++) begin
                codes_nxt[i] = codes_r[i-1];
                codes_nxt[i][STAGE_BITS*i +: STAGE_BITS] = stage_decide(res_r[i-1]);
                res_nxt[i] = stage_residue(res_r[i-1], stage_decide(res_r[i-1]));
                v_nxt[i]   = v_r[i-1];
            end
            // The last stage is a plain 2-bit flash of the final residue.
            codes_nxt[STAGES-1] = codes_r[STAGES-2];
            codes_nxt[STAGES-1][CODE_W-1 -: STAGE_BITS] =
                res_r[STAGES-2][AIN_W-1 -: STAGE_BITS];
            v_nxt[STAGES-1] = v_r[STAGES-2];
            corr_nxt   = correct(codes_r[STAGES-1]);
            corr_v_nxt = v_r[STAGES-1];
            tail_nxt[0]   = corr_r;
            tail_v_nxt[0] = corr_v_r;
            for (int k = 1; k < TAIL; k++) begin
                tail_nxt[k]   = tail_r[k-1];
                tail_v_nxt[k] = tail_v_r[k-1];
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            hold_r   <= '0;
            hold_v_r <= 1'b0;
            res_r    <= '{default: '0};
            codes_r  <= '{default: '0};
            v_r      <= '0;
            corr_r   <= '0;
            corr_v_r <= 1'b0;
            tail_r   <= '{default: '0};
            tail_v_r <= '0;
        end else if (ce) begin
            hold_r   <= hold_nxt;
            hold_v_r <= hold_v_nxt;
            res_r    <= res_nxt;
            codes_r  <= codes_nxt;
            v_r      <= v_nxt;
            corr_r   <= corr_nxt;
            corr_v_r <= corr_v_nxt;
            tail_r   <= tail_nxt;
            tail_v_r <= tail_v_nxt;
        end
    end

    // Output pins, strobe and tap overflow.
    logic [WORD_W-1:0] out_r, out_nxt;
    logic              oe_r, oe_nxt;
    logic              strobe_r, strobe_nxt;
    logic              lost_r, lost_nxt;
    logic              fifo_ready;

    always_comb begin
        out_nxt    = out_r;
        strobe_nxt = sub_edge && tail_v_r[TAIL-1];
        if (strobe_nxt) begin
            out_nxt = apply_coding(tail_r[TAIL-1], top_bit_invert_sel);
        end
        // The float control is meant as a static test strap; toggling it
        // mid-conversion only releases the pins, it never stalls the pipe.
        oe_nxt   = !out_float;
        lost_nxt = strobe_r && !fifo_ready;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            out_r    <= RESULT_RESET;
            oe_r     <= 1'b0;
            strobe_r <= 1'b0;
            lost_r   <= 1'b0;
        end else if (ce) begin
            out_r    <= out_nxt;
            oe_r     <= oe_nxt;
            strobe_r <= strobe_nxt;
            lost_r   <= lost_nxt;
        end
    end

    // The converter cannot stall, so a full tap drops the word and pulses tap_lost.
    pao_fifo #(
        .W     (WORD_W),
        .DEPTH (TAP_DEPTH)
    ) u_tap (
        .clk       (clk),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (strobe_r),
        .in_data   (out_r),
        .in_ready  (fifo_ready),
        .out_valid (tap_valid),
        .out_data  (tap_data),
        .out_ready (tap_ready)
    );

    assign result_word = out_r;
    assign result_oe   = oe_r;
    assign word_strobe = strobe_r;
    assign track_phase = phi1_r;
    assign hold_phase  = phi2_r;
    assign tap_space   = fifo_ready;
    assign tap_lost    = lost_r;

    // Reference pipe for the checks below: each sample rides along with its
    // edge count so the word can be compared with the ideal code.
    logic [AIN_W-1:0] chk_r [LATENCY_HALF_CYCLES+1];
    logic [LATENCY_HALF_CYCLES:0] chk_v_r;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            chk_r   <= '{default: '0};
            chk_v_r <= '0;
        end else if (ce && sub_edge) begin
            chk_r[0]   <= ain_level;
            chk_v_r[0] <= fall;
            for (int k = 1; k <= LATENCY_HALF_CYCLES; k++) begin
                chk_r[k]   <= chk_r[k-1];
                chk_v_r[k] <= chk_v_r[k-1];
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_track_end;
        $fell(phi1_r);
    endsequence

    a_latency_exact: assert property (
        (ce && strobe_r) |-> chk_v_r[LATENCY_HALF_CYCLES] && result_word ==
            apply_coding(chk_r[LATENCY_HALF_CYCLES][AIN_W-1 -: WORD_W],
                         $past(top_bit_invert_sel)))
        else $error("word does not match sample taken 6.5 cycles earlier");
    a_full_scale_ones: assert property (
        (ce && strobe_r && !$past(top_bit_invert_sel)
            && (&chk_r[LATENCY_HALF_CYCLES][AIN_W-1 -: WORD_W])) |-> (&result_word))
        else $error("full scale input did not give all ones");
    a_msb_invert_only: assert property (
        (ce && strobe_r) |-> result_word[RESULT_BIT_TOP] ==
            (chk_r[LATENCY_HALF_CYCLES][AIN_W-1] ^ $past(top_bit_invert_sel)))
        else $error("top bit coding wrong");
    a_float_release: assert property (
        ce |=> (result_oe == !$past(out_float)))
        else $error("output enable does not follow float control");
    a_stage_code_range: assert property (
        v_r[STAGES-1] |-> codes_r[STAGES-1][1:0] != 2'h3
            && codes_r[STAGES-1][CODE_W-3 -: STAGE_BITS] != 2'h3)
        else $error("redundant stage produced an illegal code");
    a_half_cycle_step: assert property (
        (ce && rise && hold_v_r) |=> v_r[0] && !hold_v_r)
        else $error("rising edge did not advance the held sample");
    a_phase_exclusive: assert property (
        !(phi1_r && phi2_r))
        else $error("track and hold phases overlap");
    a_phase_gap: assert property (
        s_track_end |-> !phi2_r)
        else $error("no gap between track and hold phases");
    a_strobe_single: assert property (
        (ce && strobe_r) |=> !strobe_r)
        else $error("word strobe longer than one cycle");

endmodule

/* hw/pao_pkg.sv */
/*
 * Shared constants for the pipelined converter output path: pipeline
 * geometry, latency, output bit positions, reset values and the
 * track-and-hold phase states.
 * Assumes one clock domain and that every user imports the whole package.
 */
package pao_pkg;

    // Pipeline geometry.
    localparam int STAGES_DEF     = 9;
    localparam int STAGE_BITS     = 2;
    localparam int WORD_W         = 10;
    localparam int AIN_W_DEF      = 12;

    // Latency from the start-convert edge to a valid word, in convert cycles.
    localparam real LATENCY_CONV_CYCLES = 6.5;
    // Both convert clock edges advance the pipe, so the latency counts in half cycles.
    localparam int LATENCY_HALF_CYCLES = int'(LATENCY_CONV_CYCLES * 2.0);

    // Output pin order: the top bit is the most significant of the word.
    localparam int RESULT_BIT_TOP    = WORD_W - 1;
    localparam int RESULT_BIT_BOTTOM = 0;

    // Reset values.
    localparam logic [WORD_W-1:0] RESULT_RESET = 10'h000;

    // Capture tap buffer.
    localparam int TAP_W_DEF     = WORD_W;
    localparam int TAP_DEPTH_DEF = 16;

    // Track-and-hold phase sequence, Gray coded along its loop.
    typedef enum logic [1:0] {
        TH_TRACK = 2'h0,
        TH_GAP_A = 2'h1,
        TH_HOLD  = 2'h3,
        TH_GAP_B = 2'h2
    } pao_th_state_type;

endpackage

/* hw/pao_fifo.sv */
/*
 * Small synchronous FIFO with a registered head word, used on the capture
 * tap of the converter output path.
 * Assumes one clock, an active-high asynchronous reset and a clock enable
 * that freezes all state while low.
 */
module pao_fifo
    import pao_pkg::*;
#(
    parameter int W     = TAP_W_DEF,
    parameter int DEPTH = TAP_DEPTH_DEF
) (
    // Clock and control.
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic         ce,
    // Fill side.
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side.
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [W-1:0]  mem_nxt [DEPTH];
    logic [PW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          rdy_r, rdy_nxt;
    logic          ov_r, ov_nxt;
    logic [W-1:0]  od_r, od_nxt;
    logic          push;
    logic          pop;

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        return (p == PTR_LAST) ? '0 : p + 1'b1;
    endfunction

    // The head register makes the drain side come straight from flops; the
    // price is one extra cycle before a word written into an empty FIFO shows.
    always_comb begin
        mem_nxt = mem_r;
        wr_nxt  = wr_r;
        rd_nxt  = rd_r;
        ov_nxt  = ov_r;
        od_nxt  = od_r;
        push    = in_valid && rdy_r;
        pop     = (cnt_r != '0) && (!ov_r || out_ready);
        if (push) begin
            mem_nxt[wr_r] = in_data;
            wr_nxt        = ptr_inc(wr_r);
        end
        if (!ov_r || out_ready) begin
            ov_nxt = pop;
            if (pop) begin
                od_nxt = mem_r[rd_r];
                rd_nxt = ptr_inc(rd_r);
            end
        end
        cnt_nxt = cnt_r + CW'(push) - CW'(pop);
        rdy_nxt = (cnt_nxt != CNT_FULL);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_r <= '{default: '0};
            wr_r  <= '0;
            rd_r  <= '0;
            cnt_r <= '0;
            rdy_r <= 1'b1;
            ov_r  <= 1'b0;
            od_r  <= '0;
        end else if (ce) begin
            mem_r <= mem_nxt;
            wr_r  <= wr_nxt;
            rd_r  <= rd_nxt;
            cnt_r <= cnt_nxt;
            rdy_r <= rdy_nxt;
            ov_r  <= ov_nxt;
            od_r  <= od_nxt;
        end
    end

    assign in_ready  = rdy_r;
    assign out_valid = ov_r;
    assign out_data  = od_r;

endmodule

/* tb/pao_capture_model.sv */
/*
 * Downstream capture logic for the converter output path: it samples the
 * parallel result pins on each word strobe and drains the capture tap.
 * Assumes the single clk domain of the design and that the bench reads the
 * captured values one edge after they are registered here.
 */
module pao_capture_model
    import pao_pkg::*;
(
    // Clock and reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // Result pins.
    input  wire logic [WORD_W-1:0] result_word,
    input  wire logic              result_oe,
    input  wire logic              word_strobe,
    // Capture tap.
    input  wire logic [WORD_W-1:0] tap_data,
    input  wire logic              tap_valid,
    output logic                   tap_ready,
    // Bench side.
    input  wire logic              stall,
    output logic [WORD_W-1:0]      pin_level,
    output logic                   cap_pulse,
    output logic [WORD_W-1:0]      cap_word,
    output logic                   drn_pulse,
    output logic [WORD_W-1:0]      drn_data
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [WORD_W-1:0] last_r;

    // A released bus shows the inverse of its last level, so a stale word never looks valid.
    assign pin_level = result_oe ? result_word : ~last_r;
    assign tap_ready = !stall;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            last_r    <= '0;
            cap_pulse <= 1'b0;
            cap_word  <= '0;
            drn_pulse <= 1'b0;
            drn_data  <= '0;
        end else begin
            last_r    <= result_oe ? result_word : last_r;
            cap_pulse <= word_strobe;
            cap_word  <= pin_level;
            drn_pulse <= tap_valid && tap_ready;
            drn_data  <= tap_data;
        end
    end
endmodule

/* tb/pipelined_adc_output_path_tb_top.sv */
/*
 * Self-checking bench for the converter output path: drives a 50% duty
 * convert clock of ten clk cycles, a stream of input levels and the static
 * straps, and checks words, latency, phases, pin release and the tap FIFO.
 * Assumes the capture model beside the design and a single clk domain.
 */
module pipelined_adc_output_path_tb_top
    import pao_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    // 13 half periods of 5 clk, plus edge detection, strobe and capture registers.
    localparam int LAT_LO  = 68;
    localparam int LAT_HI  = 68;
    localparam int CYC_MAX = 5000;

    logic              clk;
    logic              rst;
    logic              ce;
    logic              conv_clk;
    logic [11:0]       ain_level;
    logic              top_bit_invert_sel;
    logic              out_float;
    logic              stall;
    logic [WORD_W-1:0] result_word;
    logic              result_oe;
    logic              word_strobe;
    logic              track_phase;
    logic              hold_phase;
    logic [WORD_W-1:0] tap_data;
    logic              tap_valid;
    logic              tap_ready;
    logic              tap_space;
    logic              tap_lost;
    logic [WORD_W-1:0] pin_level;
    logic              cap_pulse;
    logic [WORD_W-1:0] cap_word;
    logic              drn_pulse;
    logic [WORD_W-1:0] drn_data;
    logic [11:0]       lvl_next;
    logic              sel_next;
    logic              sel_s;
    logic              skip;
    logic [11:0]       exp_lvl[$];
    int                exp_cyc[$];
    logic [WORD_W-1:0] tapq[$];
    int                cyc;
    int                ph;
    int                first_lat;
    int                lost_cnt;
    int                drn_cnt;
    int                err_count;
    int                checked;

    pao_adc_path #(.AIN_W(12), .TAP_DEPTH(TAP_DEPTH_DEF)) DUT (
        .clk(clk), .rst(rst), .ce(ce), .conv_clk(conv_clk), .ain_level(ain_level),
        .top_bit_invert_sel(top_bit_invert_sel), .out_float(out_float),
        .result_word(result_word), .result_oe(result_oe), .word_strobe(word_strobe),
        .track_phase(track_phase), .hold_phase(hold_phase), .tap_data(tap_data),
        .tap_valid(tap_valid), .tap_ready(tap_ready), .tap_space(tap_space),
        .tap_lost(tap_lost)
    );

    pao_capture_model u_model (
        .clk(clk), .rst(rst), .result_word(result_word), .result_oe(result_oe),
        .word_strobe(word_strobe), .tap_data(tap_data), .tap_valid(tap_valid),
        .tap_ready(tap_ready), .stall(stall), .pin_level(pin_level),
        .cap_pulse(cap_pulse), .cap_word(cap_word), .drn_pulse(drn_pulse),
        .drn_data(drn_data)
    );

    always #5 clk = ~clk;

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // Convert clock: ten clk cycles, five high and five low; the input changes at the rise, far
    // from the capturing fall, and the strap at the fall, far from the word load at the rise.
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc >= CYC_MAX) begin
            err_count++;
            summarize();
        end else if (!rst) begin
            ph <= (ph == 9) ? 0 : ph + 1;
            if (ph == 9) begin
                conv_clk           <= 1'b0;
                top_bit_invert_sel <= sel_next;
                exp_lvl.push_back(ain_level);
                exp_cyc.push_back(cyc);
            end
            if (ph == 4) begin
                conv_clk  <= 1'b1;
                ain_level <= lvl_next;
            end
        end
    end

    // Every captured word outside the float test is judged against the sample level of its capturing fall.
    always @(posedge clk) begin
        logic [11:0] lvl;
        int          lat;
        if (word_strobe === 1'b1) begin
            sel_s = top_bit_invert_sel;
            tapq.push_back(result_word);
        end
        if (cap_pulse === 1'b1 && exp_lvl.size() > 0) begin
            lvl = exp_lvl.pop_front();
            lat = cyc - exp_cyc.pop_front();
            if (!skip) begin
                check("result_word", {6'h00, lvl[11:2] ^ {sel_s, 9'h000}}, {6'h00, cap_word});
                if (first_lat < 0) first_lat = lat;
                check("latency", 16'(first_lat), 16'(lat));
            end
        end
        if (tap_lost === 1'b1) begin
            lost_cnt++;
            void'(tapq.pop_back());
        end
        if (drn_pulse === 1'b1) begin
            drn_cnt++;
            check("tap_data", {6'h00, tapq.pop_front()}, {6'h00, drn_data});
        end
        if (track_phase === 1'b1 && hold_phase === 1'b1) check("phase overlap", 16'h0000, 16'h0001);
    end

    task automatic test_reset();
        check("result_word", 16'h0000, {6'h00, result_word});
        check("result_oe", 16'h0000, {15'h0000, result_oe});
        check("word_strobe", 16'h0000, {15'h0000, word_strobe});
        check("track_phase", 16'h0001, {15'h0000, track_phase});
        check("hold_phase", 16'h0000, {15'h0000, hold_phase});
        check("tap_valid", 16'h0000, {15'h0000, tap_valid});
        check("tap_space", 16'h0001, {15'h0000, tap_space});
        check("tap_lost", 16'h0000, {15'h0000, tap_lost});
        $display("test reset done");
    endtask

    task automatic test_codes();
        logic [11:0] tbl[14];
        int          n0;
        tbl = '{12'hfff, 12'h000, 12'h800, 12'h7ff, 12'h004, 12'h003, 12'h600,
                12'h5ff, 12'ha00, 12'h9ff, 12'h555, 12'haaa, 12'hffc, 12'h001};
        n0 = checked;
        for (int s = 0; s < 2; s++) begin
            for (int i = 0; i < 14; i++) begin
                lvl_next <= tbl[i];
                sel_next <= s[0];
                repeat (10) @(posedge clk);
            end
        end
        repeat (90) @(posedge clk);
        check("latency low", 16'h0001, {15'h0000, first_lat >= LAT_LO});
        check("latency high", 16'h0001, {15'h0000, first_lat <= LAT_HI});
        check("word count", 16'h0001, {15'h0000, (checked - n0) >= 58});
        $display("test codes done");
    endtask

    task automatic test_phases();
        int nt;
        int nh;
        nt = 0;
        nh = 0;
        repeat (10) begin
            @(posedge clk);
            #1;
            nt += (track_phase === 1'b1);
            nh += (hold_phase === 1'b1);
        end
        check("track seen", 16'h0001, {15'h0000, nt > 0});
        check("hold seen", 16'h0001, {15'h0000, nh > 0});
        $display("test phases done");
    endtask

    task automatic test_float();
        skip = 1'b1;
        // The float strap is used as a test setting only, never as a shared-bus control.
        @(posedge clk);
        out_float <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        check("result_oe released", 16'h0000, {15'h0000, result_oe});
        @(posedge clk);
        out_float <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        check("result_oe driven", 16'h0001, {15'h0000, result_oe});
        repeat (80) @(posedge clk);
        skip = 1'b0;
        $display("test float done");
    endtask

    task automatic test_tap();
        int n0;
        int k;
        stall <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (tap_space !== 1'b0 && k < 400);
        check("tap_space full", 16'h0000, {15'h0000, tap_space});
        repeat (30) @(posedge clk);
        check("tap_lost seen", 16'h0001, {15'h0000, lost_cnt > 0});
        n0 = drn_cnt;
        stall <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1;
            k++;
        end while (tap_valid !== 1'b0 && k < 200);
        check("tap drained", 16'h0000, {15'h0000, tap_valid});
        check("drain count", 16'h0001, {15'h0000, (drn_cnt - n0) >= TAP_DEPTH_DEF});
        check("tap queue", 16'h0001, {15'h0000, tapq.size() <= 1});
        $display("test tap done");
    endtask

    initial begin
        clk                = 1'b0;
        rst                = 1'b1;
        ce                 = 1'b1;
        conv_clk           = 1'b1;
        ain_level          = 12'h000;
        top_bit_invert_sel = 1'b0;
        out_float          = 1'b0;
        stall              = 1'b0;
        lvl_next           = 12'h000;
        sel_next           = 1'b0;
        sel_s              = 1'b0;
        skip               = 1'b0;
        cyc                = 0;
        ph                 = 0;
        first_lat          = -1;
        lost_cnt           = 0;
        drn_cnt            = 0;
        err_count          = 0;
        checked            = 0;
        repeat (3) @(posedge clk);
        #1;
        test_reset();
        @(posedge clk);
        rst <= 1'b0;
        test_codes();
        test_phases();
        test_float();
        test_tap();
        summarize();
    end
endmodule
